//--- vis_core.sv
// Vectored interrupt system with AHB-Lite register slave
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// How it works
// - Twelve vectors, four priority levels arbitrated
// - Timers, serial and converter raise requests
// - CAN and software share vector 004B
// - Six external pins with their own vectors
// - Timer 2 trigger pin can raise request
// - Low pin in power-down wakes, vector 007B
// - Fixed vectors for timers, serial, converter
// - Timer 2 overflow and reload share 002B
// - Trigger flag set only when pin enabled
// - Enabled request ends idle, clock resumes
module vis_core
   import vis_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic timer0_ovf_evt,
   input wire logic timer1_ovf_evt,
   input wire logic rx_done_evt,
   input wire logic tx_done_evt,
   input wire logic timer2_ovf_evt,
   input wire logic conversion_done_evt,
   input wire logic can_irq,
   input wire logic ext_irq0_pin,
   input wire logic ext_irq1_pin,
   input wire logic [3:0] ext_irq_hi_pin,
   input wire logic timer2_trigger_pin,
   input wire logic can_receive_pin,
   input wire logic core_ack,
   input wire logic core_reti,
   output logic core_req,
   output logic [15:0] core_vector,
   output logic [1:0] core_level,
   output logic cpu_clock_run,
   output logic irq
);
   vis_ahb_t ap_ff;
   vis_core_t core_ff;
   vis_core_t nxt_core;
   logic [31:0] hrdata_ff;
   logic hreadyout_ff;
   logic hresp_ff;
   logic [VIS_NFLAG-1:0] flags_ff;
   logic [VIS_NFLAG-1:0] nxt_flags;
   logic [VIS_NFLAG-1:0] mask_ff;
   logic [31:0] en_ff;
   logic [2*VIS_NVEC-1:0] prio_ff;
   logic [2:0] ctrl_ff;
   logic [VIS_NLVL-1:0] isr_ff;
   logic wake_pend_ff;
   logic irq_ff;
   logic run_ff;
   logic ext0_prev_ff;
   logic ext1_prev_ff;
   logic [3:0] exthi_prev_ff;
   logic trig_prev_ff;
   logic ap_valid;
   logic wr_en;
   logic [31:0] rd_mux;
   logic [VIS_NVEC-1:0] src_req;
   logic [VIS_NVEC-1:0] act_req;
   logic found;
   logic [3:0] best_idx;
   logic [1:0] best_lvl;
   logic [2:0] isr_top;
   logic wake_evt;

   // AHB-Lite slave: zero wait states, always OKAY
   assign ap_valid = hsel & htrans[1] & hready;
   assign wr_en = ap_ff.sel & ap_ff.wr;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_ff <= '0;
      end else if (hready) begin
         ap_ff.sel <= ap_valid;
         ap_ff.wr <= hwrite;
         ap_ff.addr <= haddr[7:0];
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      case (haddr[7:0])
         VIS_FLAGS_OFS: rd_mux = {18'h00000, flags_ff};
         VIS_MASK_OFS: rd_mux = {18'h00000, mask_ff};
         VIS_ENABLE_OFS: rd_mux = en_ff;
         VIS_PRIO_OFS: rd_mux = {8'h00, prio_ff};
         VIS_CTRL_OFS: rd_mux = {29'h00000000, ctrl_ff};
         VIS_STATUS_OFS: rd_mux = {8'h00, isr_ff, 2'h0, wake_pend_ff, core_ff.req,
                                   core_ff.vector};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h00000000;
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
      end else begin
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
         if (ap_valid && !hwrite) begin
            hrdata_ff <= rd_mux;
         end
      end
   end

   // Plain read/write registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_ff <= VIS_MASK_RST;
         en_ff <= VIS_ENABLE_RST;
         prio_ff <= VIS_PRIO_RST;
      end else if (wr_en) begin
         case (ap_ff.addr)
            VIS_MASK_OFS: mask_ff <= hwdata[VIS_NFLAG-1:0];
            VIS_ENABLE_OFS: en_ff <= {hwdata[VIS_GLOBAL_EN], 19'h00000,
                                      hwdata[VIS_NVEC-1:0]};
            VIS_PRIO_OFS: prio_ff <= hwdata[2*VIS_NVEC-1:0];
            default: ;
         endcase
      end
   end

   // Pin history for edge detection; pins idle high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext0_prev_ff <= 1'b1;
         ext1_prev_ff <= 1'b1;
         exthi_prev_ff <= 4'hF;
         trig_prev_ff <= 1'b1;
      end else begin
         ext0_prev_ff <= ext_irq0_pin;
         ext1_prev_ff <= ext_irq1_pin;
         exthi_prev_ff <= ext_irq_hi_pin;
         trig_prev_ff <= timer2_trigger_pin;
      end
   end

   // Request flags: write one clears, ack clears the flags of vectors 0003 to 001B, a new event wins
   always_comb begin
      nxt_flags = flags_ff;
      if (wr_en && ap_ff.addr == VIS_FLAGS_OFS) begin
         nxt_flags = nxt_flags & ~hwdata[VIS_NFLAG-1:0];
      end
      if (core_ack && core_ff.req && core_ff.vector != VIS_VEC_WAKE) begin
         case (core_ff.vector)
            VIS_VEC_TABLE[0]: nxt_flags[VIS_F_EXT0] = 1'b0;
            VIS_VEC_TABLE[1]: nxt_flags[VIS_F_T0] = 1'b0;
            VIS_VEC_TABLE[2]: nxt_flags[VIS_F_EXT1] = 1'b0;
            VIS_VEC_TABLE[3]: nxt_flags[VIS_F_T1] = 1'b0;
            default: ;
         endcase
      end
      if (ext0_prev_ff && !ext_irq0_pin) nxt_flags[VIS_F_EXT0] = 1'b1;
      if (ext1_prev_ff && !ext_irq1_pin) nxt_flags[VIS_F_EXT1] = 1'b1;
      if (timer0_ovf_evt) nxt_flags[VIS_F_T0] = 1'b1;
      if (timer1_ovf_evt) nxt_flags[VIS_F_T1] = 1'b1;
      if (rx_done_evt) nxt_flags[VIS_F_RX] = 1'b1;
      if (tx_done_evt) nxt_flags[VIS_F_TX] = 1'b1;
      if (timer2_ovf_evt) nxt_flags[VIS_F_T2OVF] = 1'b1;
      if (trig_prev_ff && !timer2_trigger_pin && ctrl_ff[VIS_C_TRIG_EN]) begin
         nxt_flags[VIS_F_T2TRIG] = 1'b1;
      end
      if (conversion_done_evt) nxt_flags[VIS_F_ADC] = 1'b1;
      if (wr_en && ap_ff.addr == VIS_CTRL_OFS && hwdata[VIS_C_SOFT_SET]) begin
         nxt_flags[VIS_F_SOFT] = 1'b1;
      end
      for (int k = 0; k < 4; k++) begin
         if (exthi_prev_ff[k] && !ext_irq_hi_pin[k]) nxt_flags[VIS_F_EXT3+k] = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_ff <= VIS_FLAGS_RST;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // Per-vector requests; shared vectors OR their sources
   always_comb begin
      src_req[0] = flags_ff[VIS_F_EXT0];
      src_req[1] = flags_ff[VIS_F_T0];
      src_req[2] = flags_ff[VIS_F_EXT1];
      src_req[3] = flags_ff[VIS_F_T1];
      src_req[4] = flags_ff[VIS_F_RX] | flags_ff[VIS_F_TX];
      src_req[5] = flags_ff[VIS_F_T2OVF] | flags_ff[VIS_F_T2TRIG];
      src_req[6] = flags_ff[VIS_F_ADC];
      src_req[7] = can_irq | flags_ff[VIS_F_SOFT];
      src_req[11:8] = flags_ff[VIS_F_EXT3+3 -: 4];
   end

   assign act_req = src_req & en_ff[VIS_NVEC-1:0] & {VIS_NVEC{en_ff[VIS_GLOBAL_EN]}};

   // Highest level wins; equal levels go to the lowest polling index
   always_comb begin
      found = 1'b0;
      best_idx = 4'h0;
      best_lvl = 2'h0;
      for (int i = VIS_NVEC - 1; i >= 0; i--) begin
         if (act_req[i] && (!found || prio_ff[2*i +: 2] >= best_lvl)) begin
            found = 1'b1;
            best_idx = 4'(i);
            best_lvl = prio_ff[2*i +: 2];
         end
      end
   end

   // Level in service, 0 when none, else level plus one
   always_comb begin
      isr_top = 3'h0;
      for (int j = 0; j < VIS_NLVL; j++) begin
         if (isr_ff[j]) isr_top = 3'(j + 1);
      end
   end

   always_comb begin
      nxt_core = '0;
      if (core_ack) begin
         nxt_core = '0;
      end else if (wake_pend_ff) begin
         nxt_core.req = 1'b1;
         nxt_core.vector = VIS_VEC_WAKE;
         nxt_core.level = 2'h3;
      end else if (found && ({1'b0, best_lvl} + 3'h1) > isr_top) begin
         nxt_core.req = 1'b1;
         nxt_core.vector = VIS_VEC_TABLE[best_idx];
         nxt_core.level = best_lvl;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_ff <= '0;
      end else begin
         core_ff <= nxt_core;
      end
   end

   // In-service levels: set on ack, highest cleared on return
   // A return in the same cycle as an ack is kept; the set wins on one bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         isr_ff <= '0;
      end else begin
         if (core_reti && isr_top != 3'h0) begin
            isr_ff[2'(isr_top - 3'h1)] <= 1'b0;
         end
         if (core_ack && core_ff.req) begin
            isr_ff[core_ff.level] <= 1'b1;
         end
      end
   end

   // Power modes and wake-up
   assign wake_evt = ctrl_ff[VIS_C_PDOWN] & (~ext_irq0_pin | ~can_receive_pin);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= VIS_CTRL_RST;
      end else begin
         if (wr_en && ap_ff.addr == VIS_CTRL_OFS) begin
            ctrl_ff <= hwdata[2:0];
         end
         if (ctrl_ff[VIS_C_IDLE] && |act_req) begin
            ctrl_ff[VIS_C_IDLE] <= 1'b0;
         end
         if (wake_evt) begin
            ctrl_ff[VIS_C_PDOWN] <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_pend_ff <= 1'b0;
      end else if (wake_evt) begin
         wake_pend_ff <= 1'b1;
      end else if (core_ack && core_ff.req && core_ff.vector == VIS_VEC_WAKE) begin
         wake_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_ff <= 1'b1;
         irq_ff <= 1'b0;
      end else begin
         run_ff <= ~ctrl_ff[VIS_C_IDLE] & ~ctrl_ff[VIS_C_PDOWN];
         irq_ff <= |(flags_ff & mask_ff);
      end
   end

   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = hresp_ff;
   assign core_req = core_ff.req;
   assign core_vector = core_ff.vector;
   assign core_level = core_ff.level;
   assign cpu_clock_run = run_ff;
   assign irq = irq_ff;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_VEC_KNOWN: assert property (core_req |-> (core_vector == VIS_VEC_WAKE) ||
      (core_vector[2:0] == 3'h3 && core_vector[15:7] == 9'h000))
      else $error("core vector outside the vector table");
   AST_GLOBAL_GATE: assert property (core_req && core_vector != VIS_VEC_WAKE |->
      $past(en_ff[VIS_GLOBAL_EN]))
      else $error("request presented without global enable");
   AST_PREEMPT: assert property (core_req && core_vector != VIS_VEC_WAKE |->
      ({1'b0, core_level} + 3'h1) > $past(isr_top))
      else $error("request does not outrank the level in service");
   AST_TRIG_SET: assert property ($fell(timer2_trigger_pin) && ctrl_ff[VIS_C_TRIG_EN]
      |=> flags_ff[VIS_F_T2TRIG])
      else $error("trigger edge did not set its flag");
   AST_TRIG_HELD: assert property ($fell(timer2_trigger_pin) && !ctrl_ff[VIS_C_TRIG_EN] &&
      !flags_ff[VIS_F_T2TRIG] |=> !flags_ff[VIS_F_T2TRIG])
      else $error("trigger flag set while pin disabled");
   AST_WAKE: assert property (wake_evt && !core_ack |=> wake_pend_ff ##1
      (core_req && core_vector == VIS_VEC_WAKE))
      else $error("wake-up did not present its vector");
   AST_IDLE_END: assert property (ctrl_ff[VIS_C_IDLE] && |act_req |=>
      !ctrl_ff[VIS_C_IDLE] ##1 (cpu_clock_run || ctrl_ff[VIS_C_PDOWN]))
      else $error("enabled request did not end idle");
   AST_SERIAL: assert property (core_req && core_vector == VIS_VEC_TABLE[VIS_V_SERIAL] |->
      $past(flags_ff[VIS_F_RX] | flags_ff[VIS_F_TX]))
      else $error("serial vector without a serial flag");
   AST_SOFT: assert property (wr_en && ap_ff.addr == VIS_CTRL_OFS &&
      hwdata[VIS_C_SOFT_SET] |=> flags_ff[VIS_F_SOFT])
      else $error("software request flag not set");
   AST_ACK_DROP: assert property (core_ack && core_req |=> !core_req)
      else $error("request still standing after ack");

   COV_WAKE: cover property (wake_evt ##[1:4] (core_req && core_vector == VIS_VEC_WAKE));
   COV_NEST: cover property (isr_ff[0] && isr_ff[3]);
   COV_IDLE_EXIT: cover property (ctrl_ff[VIS_C_IDLE] ##1 !ctrl_ff[VIS_C_IDLE]);
endmodule : vis_core

//--- vis_pkg.sv
// Constants, register map and carrier types of the vectored interrupt system
package vis_pkg;
   localparam int VIS_NVEC = 12;
   localparam int VIS_NFLAG = 14;
   localparam int VIS_NLVL = 4;
   // Register byte offsets
   localparam logic [7:0] VIS_FLAGS_OFS = 8'h00;
   localparam logic [7:0] VIS_MASK_OFS = 8'h04;
   localparam logic [7:0] VIS_ENABLE_OFS = 8'h08;
   localparam logic [7:0] VIS_PRIO_OFS = 8'h0C;
   localparam logic [7:0] VIS_CTRL_OFS = 8'h10;
   localparam logic [7:0] VIS_STATUS_OFS = 8'h14;
   // Reset values
   localparam logic [VIS_NFLAG-1:0] VIS_FLAGS_RST = 14'h0000;
   localparam logic [VIS_NFLAG-1:0] VIS_MASK_RST = 14'h0000;
   localparam logic [31:0] VIS_ENABLE_RST = 32'h00000000;
   localparam logic [2*VIS_NVEC-1:0] VIS_PRIO_RST = 24'h000000;
   localparam logic [2:0] VIS_CTRL_RST = 3'h0;
   // Request flag positions
   localparam int VIS_F_EXT0 = 0;
   localparam int VIS_F_T0 = 1;
   localparam int VIS_F_EXT1 = 2;
   localparam int VIS_F_T1 = 3;
   localparam int VIS_F_RX = 4;
   localparam int VIS_F_TX = 5;
   localparam int VIS_F_T2OVF = 6;
   localparam int VIS_F_T2TRIG = 7;
   localparam int VIS_F_ADC = 8;
   localparam int VIS_F_SOFT = 9;
   localparam int VIS_F_EXT3 = 10;
   // Control and enable bit positions
   localparam int VIS_C_TRIG_EN = 0;
   localparam int VIS_C_IDLE = 1;
   localparam int VIS_C_PDOWN = 2;
   localparam int VIS_C_SOFT_SET = 3;
   localparam int VIS_GLOBAL_EN = 31;
   // Vector addresses in polling order, index 0 polled first
   localparam logic [15:0] VIS_VEC_TABLE [VIS_NVEC] = '{
      16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
      16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B};
   localparam logic [15:0] VIS_VEC_WAKE = 16'h007B;
   localparam int VIS_V_SERIAL = 4;
   typedef struct packed {
      logic sel;
      logic wr;
      logic [7:0] addr;
   } vis_ahb_t;
   typedef struct packed {
      logic req;
      logic [15:0] vector;
      logic [1:0] level;
   } vis_core_t;
endpackage : vis_pkg

//--- vis_core_model.sv
// Behavioural model of the processor core that takes interrupt vectors
`timescale 1ns/1ps
module vis_core_model
   import vis_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic core_req,
   input wire logic [15:0] core_vector,
   input wire logic accept,
   input wire logic [7:0] svc_len,
   output logic core_ack,
   output logic core_reti,
   output logic [15:0] taken_vec,
   output logic [7:0] ack_cnt
);
   logic [7:0] depth;
   logic [7:0] svc;
   // Ack pulse is raised while a request stands and accept is high; nested services unwind one reti each
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_ack <= 1'b0;
         core_reti <= 1'b0;
         taken_vec <= 16'h0000;
         ack_cnt <= 8'h00;
         depth <= 8'h00;
         svc <= 8'h00;
      end else begin
         core_ack <= accept && core_req && !core_ack;
         core_reti <= 1'b0;
         if (core_ack && core_req) begin
            taken_vec <= core_vector;
            ack_cnt <= ack_cnt + 8'h01;
            depth <= depth + 8'h01;
            svc <= svc_len;
         end else if (depth != 8'h00 && svc == 8'h00 && !core_reti) begin
            core_reti <= 1'b1;
            depth <= depth - 8'h01;
            svc <= svc_len;
         end else if (svc != 8'h00) begin
            svc <= svc - 8'h01;
         end
      end
   end
endmodule : vis_core_model

//--- test_vectored_interrupt_system.sv
// Self-checking testbench of the vectored interrupt system
`timescale 1ns/1ps
module test_vectored_interrupt_system
   import vis_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, core_ack, core_reti, core_req, irq;
   logic t0e, t1e, rxe, txe, t2e, cve, can_irq, p0, p1, tpin, rxc, accept, cpu_clock_run;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, core_level;
   logic [2:0] hsize;
   logic [3:0] phi;
   logic [15:0] core_vector, taken_vec;
   logic [7:0] ack_cnt, svc_len;
   int errors, checks;
   logic [15:0] exp_vec [15] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h0023,
      16'h002B, 16'h002B, 16'h0043, 16'h004B, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B};

   vis_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .timer0_ovf_evt(t0e), .timer1_ovf_evt(t1e),
      .rx_done_evt(rxe), .tx_done_evt(txe), .timer2_ovf_evt(t2e), .conversion_done_evt(cve),
      .can_irq(can_irq), .ext_irq0_pin(p0), .ext_irq1_pin(p1), .ext_irq_hi_pin(phi),
      .timer2_trigger_pin(tpin), .can_receive_pin(rxc), .core_ack(core_ack),
      .core_reti(core_reti), .core_req(core_req), .core_vector(core_vector),
      .core_level(core_level), .cpu_clock_run(cpu_clock_run), .irq(irq));

   vis_core_model core (.hclk(hclk), .hresetn(hresetn), .core_req(core_req),
      .core_vector(core_vector), .accept(accept), .svc_len(svc_len), .core_ack(core_ack),
      .core_reti(core_reti), .taken_vec(taken_vec), .ack_cnt(ack_cnt));

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task automatic print_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            errors++;
            print_verdict();
         end
         @(posedge hclk);
      end
   endtask : wait_rdy

   // One AHB single transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      chk(q, e);
   endtask : rdc

   // Raise one interrupt source for one cycle, except can_irq (10) which stays high; pins fall and rise again
   task automatic fire(input int s);
      case (s)
         0: p0 <= 1'b0;
         1: t0e <= 1'b1;
         2: p1 <= 1'b0;
         3: t1e <= 1'b1;
         4: rxe <= 1'b1;
         5: txe <= 1'b1;
         6: t2e <= 1'b1;
         7: tpin <= 1'b0;
         8: cve <= 1'b1;
         9: wr(VIS_CTRL_OFS, 32'h00000009);
         10: can_irq <= 1'b1;
         default: phi <= ~(4'h1 << (s - 11));
      endcase
      @(posedge hclk);
      {t0e, t1e, rxe, txe, t2e, cve} <= 6'h00;
      {p0, p1, tpin} <= 3'h7;
      phi <= 4'hF;
   endtask : fire

   // Wait for the core to take a vector, then compare it
   task automatic take(input logic [15:0] e, input int lim);
      logic [7:0] c;
      int n;
      c = ack_cnt;
      n = 0;
      while (ack_cnt === c) begin
         @(posedge hclk);
         n++;
         if (n > lim) begin
            errors++;
            print_verdict();
         end
      end
      chk({16'h0000, taken_vec}, {16'h0000, e});
   endtask : take

   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      {t0e, t1e, rxe, txe, t2e, cve, can_irq, accept} = 8'h00;
      {p0, p1, tpin, rxc, phi} = 8'hFF;
      svc_len = 8'h08;
      errors = 0;
      checks = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int a = 0; a <= 24; a += 4) rdc(a[7:0], 32'h00000000);
      chk({31'h0, hresp}, 32'h00000000);
      chk({31'h0, cpu_clock_run}, 32'h00000001);
      wr(VIS_MASK_OFS, 32'hFFFFFFFF);
      rdc(VIS_MASK_OFS, 32'h00003FFF);
      wr(8'h18, 32'hFFFFFFFF);
      rdc(8'h18, 32'h00000000);
      $display("test registers done");
      fire(7);
      repeat (3) @(posedge hclk);
      rdc(VIS_FLAGS_OFS, 32'h00000000);
      wr(VIS_ENABLE_OFS, 32'h00000FFF);
      fire(4);
      repeat (3) @(posedge hclk);
      chk({31'h0, core_req}, 32'h00000000);
      chk({31'h0, irq}, 32'h00000001);
      wr(VIS_MASK_OFS, 32'h00000000);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h00000000);
      wr(VIS_FLAGS_OFS, 32'h00003FFF);
      $display("test enables done");
      wr(VIS_ENABLE_OFS, 32'h80000FFF);
      wr(VIS_CTRL_OFS, 32'h00000001);
      for (int s = 0; s < 15; s++) begin
         accept <= 1'b1;
         fire(s);
         take(exp_vec[s], 40);
         accept <= 1'b0;
         can_irq <= 1'b0;
         wr(VIS_FLAGS_OFS, 32'h00003FFF);
      end
      $display("test vectors done");
      wr(VIS_PRIO_OFS, 32'h00030000);
      fire(3);
      fire(1);
      repeat (12) @(posedge hclk);
      chk({16'h0000, core_vector}, 32'h0000000B);
      svc_len <= 8'h3C;
      accept <= 1'b1;
      take(16'h000B, 10);
      fire(11);
      take(16'h0053, 10);
      wr(VIS_FLAGS_OFS, 32'h00000400);
      take(16'h001B, 200);
      accept <= 1'b0;
      wr(VIS_FLAGS_OFS, 32'h00003FFF);
      $display("test priority done");
      svc_len <= 8'h08;
      accept <= 1'b1;
      wr(VIS_CTRL_OFS, 32'h00000002);
      repeat (2) @(posedge hclk);
      chk({31'h0, cpu_clock_run}, 32'h00000000);
      fire(1);
      take(16'h000B, 80);
      repeat (2) @(posedge hclk);
      chk({31'h0, cpu_clock_run}, 32'h00000001);
      $display("test idle done");
      wr(VIS_ENABLE_OFS, 32'h00000000);
      for (int w = 0; w < 2; w++) begin
         wr(VIS_CTRL_OFS, 32'h00000004);
         repeat (2) @(posedge hclk);
         chk({31'h0, cpu_clock_run}, 32'h00000000);
         if (w == 0) rxc <= 1'b0;
         else p0 <= 1'b0;
         @(posedge hclk);
         {rxc, p0} <= 2'h3;
         repeat (2) @(posedge hclk);
         chk({30'h0, core_level}, 32'h00000003);
         take(16'h007B, 20);
         repeat (2) @(posedge hclk);
         chk({31'h0, cpu_clock_run}, 32'h00000001);
      end
      wr(VIS_FLAGS_OFS, 32'h00003FFF);
      $display("test wake done");
      print_verdict();
   end
endmodule : test_vectored_interrupt_system
